// file: pkg/rst_led_pkg.sv
// Purpose: Constants and types shared by the reset and indicator block
// Assumes: 200 MHz system clock
// Notes:   Cycle counts are derived from the clock rate
// How it works
// - Addressing channel drives red pin
// - Addressing active plus bicolor: green released
// - Master/repeater/monitor: red carries resynced Manchester
// - Equal polarity selects: active high, idle 0
// - Unequal polarity selects: active low, idle 1
// - Telegram error corrupts forwarded Manchester stream
// - Master/repeater/monitor: green held high-impedance
// - Any reset presets outputs ones, released
// - Non power-on reset pulses both strobes
// - Reset sets exchange-block flag, blocks data port
// - Soft or external reset init within 2 ms
// - Power-on init within 30 or 1000 ms
// - Power-on reset pulse 4 to 6 us
// - Node, broadcast, watchdog, forbidden state reset
// - Long low strobe pin resets every mode
// - Low up to 35 us starts nothing
// - Outputs released within 44 us of fall
// - Reset timer expiry starts init immediately
package rst_led_pkg;
  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned NORESET_US      = 35;
  localparam int unsigned RESET_EXEC_US   = 44;
  localparam int unsigned POR_MIN_US      = 4;
  localparam int unsigned POR_MAX_US      = 6;
  localparam int unsigned INIT_SOFT_MS    = 2;
  localparam int unsigned INIT_POR_MS     = 30;
  localparam int unsigned INIT_POR_BIG_MS = 1000;
  // Reset timer fires after the no-reset window, before release deadline
  localparam int unsigned EXT_RST_CYC     = (NORESET_US + 1) * CLK_MHZ;
  localparam int unsigned POR_CYC         = ((POR_MIN_US + POR_MAX_US) / 2) * CLK_MHZ;
  localparam int unsigned INIT_SOFT_CYC   = INIT_SOFT_MS * 1000 * CLK_MHZ;
  localparam int unsigned INIT_POR_CYC    = INIT_POR_MS * 1000 * CLK_MHZ;
  localparam int unsigned INIT_POR_BIG_CYC = INIT_POR_BIG_MS * 1000 * CLK_MHZ;
  localparam logic [3:0]  PORT_PRESET     = 4'hF;
  localparam logic [3:0]  PORT_ZERO       = 4'h0;
  localparam logic [1:0]  MODE_SLAVE      = 2'h0;

  typedef enum logic [3:0] {
    ST_POR  = 4'b0001,
    ST_RST  = 4'b0010,
    ST_INIT = 4'b0100,
    ST_RUN  = 4'b1000
  } seq_state_e;
endpackage

// file: src/word_buf2.sv
// Purpose: Two-entry valid/ready buffer
// Assumes: Single clock
// Notes:   Full throughput, no combinational ready path from output
`timescale 1ns/1ps
module word_buf2 #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             i_clk,    // Clock
  input  wire logic             i_nrst,   // Async reset, low
  input  wire logic             i_valid,  // Input valid
  output logic                  o_ready,  // Input ready
  input  wire logic [WIDTH-1:0] i_data,   // Input word
  output logic                  o_valid,  // Output valid
  input  wire logic             i_ready,  // Output ready
  output logic [WIDTH-1:0]      o_data    // Output word
);
  logic [WIDTH-1:0] mem_ff [2];
  logic             wp_ff;
  logic             rp_ff;
  logic [1:0]       cnt_ff;
  logic             push;
  logic             pop;

  assign o_ready = (cnt_ff != 2'd2);
  assign o_valid = (cnt_ff != 2'd0);
  assign o_data  = mem_ff[rp_ff];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_ff  <= 1'b0;
      rp_ff  <= 1'b0;
      cnt_ff <= 2'd0;
    end else begin
      if (push) wp_ff <= ~wp_ff;
      if (pop) rp_ff <= ~rp_ff;
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
    end else if (push) begin
      mem_ff[wp_ff] <= i_data;
    end
  end
endmodule

// file: src/rst_led_ctrl.sv
// Purpose: Reset sequencing, output preset and indicator pin control
// Assumes: One 200 MHz clock; power-on detect and telegram decoder outside
// Notes:   Data words pass a two-entry buffer before the data port
`timescale 1ns/1ps
module rst_led_ctrl
  import rst_led_pkg::*;
#(
  parameter int unsigned EXT_RST_CYCLES  = rst_led_pkg::EXT_RST_CYC,
  parameter int unsigned POR_CYCLES      = rst_led_pkg::POR_CYC,
  parameter int unsigned INIT_SOFT_CYCLES = rst_led_pkg::INIT_SOFT_CYC,
  parameter int unsigned INIT_POR_CYCLES = rst_led_pkg::INIT_POR_CYC,
  parameter int unsigned INIT_BIG_CYCLES = rst_led_pkg::INIT_POR_BIG_CYC
) (
  input  wire logic       i_clk,              // System clock
  input  wire logic       i_nrst,             // Power-on reset, low
  input  wire logic       i_big_load,         // High-capacitance output load
  input  wire logic       i_node_reset,       // Node reset call pulse
  input  wire logic       i_bcast_reset,      // Broadcast reset call pulse
  input  wire logic       i_wdog_en,          // Watchdog enabled
  input  wire logic       i_wdog_expire,      // Watchdog expiry pulse
  input  wire logic       i_bad_state,        // Forbidden state pulse
  input  wire logic       i_strobe_rst_n,     // Strobe/reset pin, low active
  input  wire logic [1:0] i_mode,             // 0 slave, else master/repeater/monitor
  input  wire logic       i_addr_active,      // Addressing channel active
  input  wire logic       i_addr_tx,          // Addressing channel output bit
  input  wire logic       i_bicolor_indicator_flag, // Bicolor mode
  input  wire logic       i_status_red,       // Status pattern for red pin
  input  wire logic       i_status_green,     // Status pattern for green pin
  input  wire logic       i_green_enable,     // Green status allowed
  input  wire logic       i_polarity_select_a, // Polarity pin a
  input  wire logic       i_polarity_select_b, // Polarity pin b
  input  wire logic       i_manch,            // Resynced Manchester, active high
  input  wire logic       i_manch_busy,       // Telegram in progress
  input  wire logic       i_tel_error,        // Telegram check failed
  input  wire logic       i_param_write,      // Parameter write pulse
  input  wire logic [3:0] i_param,            // Parameter word
  input  wire logic       i_data_valid,       // Data exchange word valid
  output logic            o_data_ready,       // Data exchange word accepted
  input  wire logic [3:0] i_data,             // Data exchange word
  input  wire logic       i_port_ready,       // Data port sink ready
  output logic [3:0]      o_data_output_pins, // Data port level
  output logic [3:0]      o_data_oe,          // Data port drive enable
  output logic [3:0]      o_parameter_output_pins, // Parameter port level
  output logic [3:0]      o_param_oe,         // Parameter port drive enable
  output logic            o_data_strobe,      // Data strobe pulse
  output logic            o_param_strobe,     // Parameter strobe pulse
  output logic            o_red_indicator_pin,   // Red pin level
  output logic            o_red_oe,           // Red pin drive enable
  output logic            o_green_indicator_pin, // Green pin level
  output logic            o_green_oe,         // Green pin drive enable
  output logic            o_xchg_block,       // Exchange-block flag
  output logic            o_init_busy         // Reset or init running
);
  import rst_led_pkg::*;

  // ===========================================================
  // Pin synchronisers
  // ===========================================================
  logic       dsr_m_ff, dsr_s_ff;
  logic [1:0] pol_m_ff, pol_s_ff;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dsr_m_ff <= 1'b1;
      dsr_s_ff <= 1'b1;
      pol_m_ff <= 2'b00;
      pol_s_ff <= 2'b00;
    end else begin
      dsr_m_ff <= i_strobe_rst_n;
      dsr_s_ff <= dsr_m_ff;
      pol_m_ff <= {i_polarity_select_a, i_polarity_select_b};
      pol_s_ff <= pol_m_ff;
    end
  end

  // ===========================================================
  // External reset timer
  // ===========================================================
  // Fires once per low phase: edge sensitive to timer expiry
  logic [31:0] ext_cnt_ff;
  logic        ext_fired_ff;
  logic        ext_hit;

  assign ext_hit = !dsr_s_ff && !ext_fired_ff && (ext_cnt_ff == EXT_RST_CYCLES - 1);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ext_cnt_ff   <= '0;
      ext_fired_ff <= 1'b0;
    end else if (dsr_s_ff) begin
      ext_cnt_ff   <= '0;
      ext_fired_ff <= 1'b0;
    end else if (ext_hit) begin
      ext_fired_ff <= 1'b1;
    end else if (!ext_fired_ff) begin
      ext_cnt_ff <= ext_cnt_ff + 32'd1;
    end
  end

  // ===========================================================
  // Reset merge and sequencer
  // ===========================================================
  logic       soft_rst;
  seq_state_e state_ff;
  logic [31:0] seq_cnt_ff;
  logic       por_path_ff;
  logic       big_ff;
  logic       rst_pulse;

  assign soft_rst = i_node_reset || i_bcast_reset || (i_wdog_en && i_wdog_expire)
                    || i_bad_state || ext_hit;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff    <= ST_POR;
      seq_cnt_ff  <= '0;
      por_path_ff <= 1'b1;
      big_ff      <= 1'b0;
    end else begin
      case (state_ff)
        ST_POR: begin
          // Internal reset pulse held for a fixed width
          if (seq_cnt_ff == POR_CYCLES - 1) begin
            state_ff   <= ST_INIT;
            seq_cnt_ff <= '0;
            big_ff     <= i_big_load;
          end else begin
            seq_cnt_ff <= seq_cnt_ff + 32'd1;
          end
        end
        ST_RST: begin
          state_ff    <= ST_INIT;
          seq_cnt_ff  <= '0;
          por_path_ff <= 1'b0;
        end
        ST_INIT: begin
          if (soft_rst) begin
            state_ff <= ST_RST;
          end else if ((!por_path_ff && seq_cnt_ff == INIT_SOFT_CYCLES - 1)
                    || (por_path_ff && !big_ff && seq_cnt_ff == INIT_POR_CYCLES - 1)
                    || (por_path_ff && big_ff && seq_cnt_ff == INIT_BIG_CYCLES - 1)) begin
            state_ff   <= ST_RUN;
            seq_cnt_ff <= '0;
          end else begin
            seq_cnt_ff <= seq_cnt_ff + 32'd1;
          end
        end
        ST_RUN: begin
          if (soft_rst) begin
            state_ff <= ST_RST;
          end
        end
        default: begin
          state_ff <= ST_RST;
        end
      endcase
    end
  end

  assign rst_pulse   = (state_ff == ST_RST);
  assign o_init_busy = (state_ff != ST_RUN);

  // ===========================================================
  // Exchange-block flag
  // ===========================================================
  logic xchg_ff;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      xchg_ff <= 1'b1;
    end else if (soft_rst || state_ff != ST_RUN) begin
      // Set on the request edge so the flag is already up in the reset cycle
      xchg_ff <= 1'b1;
    end else if (state_ff == ST_RUN && i_param_write) begin
      xchg_ff <= 1'b0;
    end
  end

  assign o_xchg_block = xchg_ff;

  // ===========================================================
  // Data path buffer
  // ===========================================================
  logic       buf_valid;
  logic       buf_ready;
  logic [3:0] buf_data;
  logic       port_open;
  logic       buf_in_ready;

  // Words are refused while blocked; words already in the buffer are kept across a soft reset
  assign port_open    = !xchg_ff && (state_ff == ST_RUN);
  assign buf_ready    = i_port_ready && port_open;
  assign o_data_ready = buf_in_ready && port_open;

  word_buf2 #(
    .WIDTH (4)
  ) u_buf (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_valid (i_data_valid && port_open),
    .o_ready (buf_in_ready),
    .i_data  (i_data),
    .o_valid (buf_valid),
    .i_ready (buf_ready),
    .o_data  (buf_data)
  );

  // ===========================================================
  // Data and parameter ports
  // ===========================================================
  logic [3:0] dout_ff, pout_ff, doe_ff, poe_ff;
  logic       dstb_ff, pstb_ff;
  logic       ext_low;

  // Release starts as soon as the timer fires, well inside the deadline
  assign ext_low = ext_hit;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dout_ff <= PORT_PRESET;
      pout_ff <= PORT_PRESET;
      doe_ff  <= PORT_ZERO;
      poe_ff  <= PORT_ZERO;
      dstb_ff <= 1'b0;
      pstb_ff <= 1'b0;
    end else begin
      dstb_ff <= 1'b0;
      pstb_ff <= 1'b0;
      if (rst_pulse || ext_low || state_ff == ST_POR) begin
        dout_ff <= PORT_PRESET;
        pout_ff <= PORT_PRESET;
        doe_ff  <= PORT_ZERO;
        poe_ff  <= PORT_ZERO;
        dstb_ff <= rst_pulse;
        pstb_ff <= rst_pulse;
      end else if (state_ff == ST_RUN) begin
        if (i_param_write) begin
          pout_ff <= i_param;
          poe_ff  <= PORT_PRESET;
          pstb_ff <= 1'b1;
        end
        if (buf_valid && buf_ready) begin
          dout_ff <= buf_data;
          doe_ff  <= PORT_PRESET;
          dstb_ff <= 1'b1;
        end
      end
    end
  end

  assign o_data_output_pins      = dout_ff;
  assign o_parameter_output_pins = pout_ff;
  assign o_data_oe               = doe_ff;
  assign o_param_oe              = poe_ff;
  assign o_data_strobe           = dstb_ff;
  assign o_param_strobe          = pstb_ff;

  // ===========================================================
  // Indicator pins
  // ===========================================================
  logic red_ff, red_oe_ff, grn_ff, grn_oe_ff;
  logic fwd_mode, inv, corrupt_ff, mbit;

  assign fwd_mode = (i_mode != MODE_SLAVE);
  assign inv      = pol_s_ff[1] ^ pol_s_ff[0];

  // Error latched until the stream goes quiet; forced level breaks coding
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      corrupt_ff <= 1'b0;
    end else if (i_tel_error) begin
      corrupt_ff <= 1'b1;
    end else if (!i_manch_busy) begin
      corrupt_ff <= 1'b0;
    end
  end

  assign mbit = i_manch_busy && (corrupt_ff || i_tel_error || i_manch);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      red_ff    <= 1'b1;
      red_oe_ff <= 1'b0;
      grn_ff    <= 1'b1;
      grn_oe_ff <= 1'b0;
    end else if (fwd_mode) begin
      red_ff    <= mbit ^ inv;
      red_oe_ff <= !(mbit ^ inv);
      grn_ff    <= 1'b1;
      grn_oe_ff <= 1'b0;
    end else if (i_addr_active) begin
      red_ff    <= i_addr_tx;
      red_oe_ff <= !i_addr_tx;
      grn_ff    <= i_bicolor_indicator_flag ? 1'b1 : i_status_green;
      grn_oe_ff <= !i_bicolor_indicator_flag && i_green_enable && !i_status_green;
    end else begin
      red_ff    <= i_status_red;
      red_oe_ff <= !i_status_red;
      grn_ff    <= i_status_green;
      grn_oe_ff <= i_green_enable && !i_status_green;
    end
  end

  assign o_red_indicator_pin   = red_ff;
  assign o_red_oe              = red_oe_ff;
  assign o_green_indicator_pin = grn_ff;
  assign o_green_oe            = grn_oe_ff;
endmodule

// file: verification/port_sink.sv
// Purpose: Data port sink model that stalls on demand
// Assumes: Ready moves only on falling clock edges
// Notes:   Slow mode stalls about four cycles in five
`timescale 1ns/1ps
module port_sink (
  input  wire logic i_clk,  // Clock
  input  wire logic i_slow, // Stall often
  output logic      o_ready // Sink ready
);
  logic [3:0] lfsr_ff;
  // ==========
  // Ready pattern
  initial begin
    lfsr_ff = 4'h1;
    o_ready = 1'b1;
  end
  always @(negedge i_clk) begin
    lfsr_ff <= {lfsr_ff[2:0], lfsr_ff[3] ^ lfsr_ff[2]};
    o_ready <= i_slow ? (lfsr_ff[1:0] == 2'h0) : 1'b1;
  end
endmodule

// file: verification/rst_led_assertions.sv
// Purpose: Port assertions for the reset and indicator block
// Assumes: One clock, reset low and asynchronous
// Notes:   Pin low time counted raw; sync delay covered by slack
`timescale 1ns/1ps
module rst_led_assertions #(
  parameter int unsigned EXT_RST_CYCLES = 20
) (
  input wire logic       i_clk,                    // Clock
  input wire logic       i_nrst,                   // Reset
  input wire logic [1:0] i_mode,                   // Mode
  input wire logic       i_addr_active,            // Addressing on
  input wire logic       i_bicolor_indicator_flag, // Bicolor
  input wire logic       i_strobe_rst_n,           // Strobe pin
  input wire logic       o_data_ready,             // Word taken
  input wire logic [3:0] o_data_output_pins,       // Data port
  input wire logic [3:0] o_data_oe,                // Data drive
  input wire logic [3:0] o_param_oe,               // Param drive
  input wire logic       o_data_strobe,            // Data strobe
  input wire logic       o_param_strobe,           // Param strobe
  input wire logic       o_red_indicator_pin,      // Red level
  input wire logic       o_red_oe,                 // Red drive
  input wire logic       o_green_indicator_pin,    // Green level
  input wire logic       o_green_oe,               // Green drive
  input wire logic       o_xchg_block,             // Blocked
  input wire logic       o_init_busy               // Busy
);
  int unsigned low_cnt_ff;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  // ==========
  // Pin low counter, saturates so it never wraps into a match
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      low_cnt_ff <= 0;
    end else if (i_strobe_rst_n) begin
      low_cnt_ff <= 0;
    end else if (low_cnt_ff < 4000) begin
      low_cnt_ff <= low_cnt_ff + 1;
    end
  end
  // ==========
  // Checks
  preset_busy_a: assert property (o_init_busy && $past(o_init_busy) |->
    o_data_oe == 4'h0 && o_param_oe == 4'h0 && o_data_output_pins == 4'hf) else $error("ports not preset");
  rst_strobe_a: assert property ($rose(o_init_busy) |-> ##[1:2] (o_data_strobe && o_param_strobe))
    else $error("no strobes after reset");
  strobe_pair_a: assert property (o_init_busy && $past(o_init_busy)
    |-> o_data_strobe == o_param_strobe) else $error("strobes apart in reset");
  xchg_busy_a: assert property (o_init_busy |-> o_xchg_block)
    else $error("block flag clear in reset");
  blocked_ready_a: assert property (o_xchg_block |-> !o_data_ready)
    else $error("word taken while blocked");
  green_fwd_a: assert property ((i_mode != 2'h0) [*3] |-> o_green_indicator_pin && !o_green_oe)
    else $error("green driven in forwarding");
  green_bicolor_a: assert property ((i_mode == 2'h0 && i_addr_active && i_bicolor_indicator_flag) [*3]
    |-> o_green_indicator_pin && !o_green_oe) else $error("green driven while addressing");
  open_drain_a: assert property ((o_red_oe |-> !o_red_indicator_pin)
    and (o_green_oe |-> !o_green_indicator_pin)) else $error("pin driven high");
  ext_release_a: assert property (low_cnt_ff == EXT_RST_CYCLES + 6 |-> o_init_busy && o_data_oe == 4'h0)
    else $error("ports not released on long low");
endmodule

bind rst_led_ctrl rst_led_assertions #(.EXT_RST_CYCLES(EXT_RST_CYCLES)) chk (.*);

// file: verification/tb.sv
// Purpose: Self-checking bench for the reset and indicator block
// Assumes: Counts shortened; inputs move on the falling edge
// Notes:   Expected data port words queue up for the strobe monitor
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
  $display("Error %0t: got %h expected %h", $time, a, b); end end
module tb;
  import rst_led_pkg::*;
  localparam int EXT = 20;
  localparam int PORW = 4;
  localparam int SOFT = 50;
  localparam int PORC = 60;
  localparam int BIG = 80;
  logic       clk = 1'b0, nrst = 1'b0, big = 1'b0, pin_n = 1'b1, wen = 1'b0, aa = 1'b0, atx = 1'b0;
  logic       bic = 1'b0, pa = 1'b0, pb = 1'b0, man = 1'b0, mbusy = 1'b0, terr = 1'b0, pw = 1'b0;
  logic       dv = 1'b0, slow = 1'b0, drdy, prdy, dstb, pstb, red, redoe, grn, grnoe, xb, busy;
  logic       sr = 1'b1, sg = 1'b0, ge = 1'b1;
  logic [1:0] mode = 2'h0;
  logic [3:0] src = 4'h0, dat = 4'h0, par = 4'h0, dpin, doe, ppin, poe;
  logic [4:0] e;
  logic [4:0] exp_q[$];
  int         err_count = 0, samples_checked = 0, cycles = 0, seed = 77, n;

  rst_led_ctrl #(.EXT_RST_CYCLES(EXT), .POR_CYCLES(PORW), .INIT_SOFT_CYCLES(SOFT),
    .INIT_POR_CYCLES(PORC), .INIT_BIG_CYCLES(BIG)) uut (
    .i_clk(clk), .i_nrst(nrst), .i_big_load(big), .i_node_reset(src[0]), .i_bcast_reset(src[1]),
    .i_wdog_en(wen), .i_wdog_expire(src[2]), .i_bad_state(src[3]), .i_strobe_rst_n(pin_n),
    .i_mode(mode), .i_addr_active(aa), .i_addr_tx(atx), .i_bicolor_indicator_flag(bic),
    .i_status_red(sr), .i_status_green(sg), .i_green_enable(ge), .i_polarity_select_a(pa),
    .i_polarity_select_b(pb), .i_manch(man), .i_manch_busy(mbusy), .i_tel_error(terr),
    .i_param_write(pw), .i_param(par), .i_data_valid(dv), .o_data_ready(drdy), .i_data(dat),
    .i_port_ready(prdy), .o_data_output_pins(dpin), .o_data_oe(doe), .o_parameter_output_pins(ppin),
    .o_param_oe(poe), .o_data_strobe(dstb), .o_param_strobe(pstb), .o_red_indicator_pin(red),
    .o_red_oe(redoe), .o_green_indicator_pin(grn), .o_green_oe(grnoe), .o_xchg_block(xb), .o_init_busy(busy));
  port_sink snk (.i_clk(clk), .i_slow(slow), .o_ready(prdy));

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      conclude();
    end
  end
  // ==========
  // Strobe monitor: every data strobe consumes the oldest expectation
  always @(negedge clk) if (dstb === 1'b1) begin
    `CHK(exp_q.size() > 0, 1'b1)
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      `CHK(({pstb, dpin}), e)
    end
  end

  task automatic conclude();
    if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic run_wait();
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic pwr(input logic bl, input int lo);
    nrst = 1'b0;
    big = bl;
    cyc(10);
    nrst = 1'b1;
    run_wait();
    `CHK(n >= lo && n <= lo + 6, 1'b1)
    `CHK(({xb, doe, poe, dpin, ppin}), {1'b1, 16'h00ff})
  endtask
  task automatic wr_par();
    par = 4'($random(seed));
    pw = 1'b1;
    cyc(1);
    pw = 1'b0;
    cyc(3);
    `CHK(({xb, poe, ppin}), {1'b0, 4'hf, par})
  endtask

  initial begin
    pwr(1'b0, PORW + PORC);
    dv = 1'b1;
    cyc(3);
    `CHK(drdy, 1'b0)
    dv = 1'b0;
    wr_par();
    slow = 1'b1;
    for (int i = 0; i < 12; i++) begin
      dat = 4'($random(seed));
      dv = 1'b1;
      #1;
      while (drdy !== 1'b1) begin
        @(negedge clk);
        #1;
      end
      exp_q.push_back({1'b0, dat});
      @(negedge clk);
    end
    dv = 1'b0;
    slow = 1'b0;
    cyc(20);
    `CHK(({exp_q.size() == 0, doe}), 5'h1f)
    src = 4'h4;
    cyc(1);
    src = 4'h0;
    cyc(4);
    `CHK(busy, 1'b0)
    wen = 1'b1;
    for (int k = 0; k < 4; k++) begin
      exp_q.push_back(5'h1f);
      src = 4'(1 << k);
      cyc(1);
      src = 4'h0;
      run_wait();
      `CHK(n >= SOFT && n <= SOFT + 6, 1'b1)
      `CHK(({xb, doe, dpin}), 9'h10f)
      wr_par();
    end
    for (int m = 0; m < 2; m++) begin
      mode = 2'(m);
      pin_n = 1'b0;
      cyc(EXT - 2);
      pin_n = 1'b1;
      cyc(10);
      `CHK(busy, 1'b0)
      exp_q.push_back(5'h1f);
      pin_n = 1'b0;
      cyc(EXT + 8);
      `CHK(({busy, doe, poe}), 9'h100)
      run_wait();
      `CHK(n <= SOFT + 6, 1'b1)
      cyc(30);
      `CHK(busy, 1'b0)
      pin_n = 1'b1;
      wr_par();
    end
    mode = 2'h1;
    for (int p = 0; p < 4; p++) begin
      {pa, pb} = 2'(p);
      man = 1'b0;
      mbusy = 1'b0;
      cyc(5);
      `CHK(({red, redoe, grn, grnoe}), {pa ^ pb, ~(pa ^ pb), 2'h2})
      man = 1'b1;
      mbusy = 1'b1;
      cyc(4);
      `CHK(red, ~(pa ^ pb))
      man = 1'b0;
      cyc(4);
      `CHK(red, pa ^ pb)
      terr = 1'b1;
      cyc(1);
      terr = 1'b0;
      cyc(3);
      `CHK(red, ~(pa ^ pb))
      mbusy = 1'b0;
    end
    mode = MODE_SLAVE;
    aa = 1'b1;
    bic = 1'b1;
    for (int i = 0; i < 4; i++) begin
      atx = i[0];
      {sr, sg, ge} = 3'($random(seed));
      cyc(4);
      `CHK(({red, redoe, grn, grnoe}), {atx, ~atx, 2'h2})
    end
    aa = 1'b0;
    cyc(4);
    `CHK(({red, grn, grnoe}), {sr, sg, ge & ~sg})
    pwr(1'b1, PORW + BIG);
    conclude();
  end
endmodule
